// ==== sfs_front_end.sv ====
// Serial flash SPI front end: framing, shifting, protection, OTP, write FIFO.
// Assumes all pins already synchronous to clk and SCK well below clk/4.
//
// Notes on behaviour
// - Chip select high deselects, goes to standby, output pin floats.
// - Deselected device ignores the serial input entirely.
// - Operation starts on chip select fall, completes on chip select rise.
// - Standby waits for a running program or erase to finish.
// - Command, address and write data sampled on SCK rising edges.
// - Read bits change on SCK falling edges.
// - All inbound traffic except dual-input program data arrives on the input line in single-bit mode.
// - Dual-output read drives two bits per falling edge, input line turned output.
// - Modes 0 and 3 both work; only rising edges sample.
// - Program takes one to 256 bytes within one page.
// - Erase of aligned 4K, 32K, 64K blocks and whole array.
// - Protection bit per 64K sector, 32 sectors, plus global set and clear.
// - 128-byte security register apart from the array, each byte programmable once until reset.
// - Dual-input program captures two bits per rising edge, output line as input.
// - Pause pin low ignores clock and data and floats outputs.
`timescale 1ns/1ps

module sfs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      wp_d;
  logic [AW:0]      rp_q;
  logic [AW:0]      rp_d;
  logic             full;

  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem_q[rp_q[AW-1:0]];

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (in_valid && in_ready) begin
      wp_d = wp_q + (AW+1)'(1);
    end
    if (out_valid && out_ready) begin
      rp_d = rp_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage carries no reset; only pointers matter after reset
  always_ff @(posedge clk) begin
    if (ce && in_valid && in_ready) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule // sfs_fifo

module sfs_front_end (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // SPI pins
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              hold_n,
  input  wire logic              input_line_dual_output_i,
  output logic                   input_line_dual_output_o,
  output logic                   input_line_dual_output_oe,
  input  wire logic              output_line_dual_input_i,
  output logic                   output_line_dual_input_o,
  output logic                   output_line_dual_input_oe,
  // Array side
  input  wire logic              busy,
  output logic [23:0]            rd_addr,
  input  wire logic [7:0]        rd_data,
  output logic                   cmd_valid,
  output sfs_pkg::sfs_cmd_t      cmd,
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output sfs_pkg::sfs_wr_t       wr_word,
  // Status
  output logic [31:0]            protect_map,
  output logic                   standby,
  output logic                   overrun
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [4:0] sect_of(input logic [23:0] a);
    return a[sfs_pkg::SECT_LSB +: sfs_pkg::SECT_W];
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    return (op == sfs_pkg::OP_PROG) || (op == sfs_pkg::OP_PROG_DUAL);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    return (op == sfs_pkg::OP_READ) || (op == sfs_pkg::OP_READ_DUAL) ||
           (op == sfs_pkg::OP_SEC_READ);
  endfunction

  function automatic logic needs_addr(input logic [7:0] op);
    return is_prog(op) || is_read(op) || (op == sfs_pkg::OP_SEC_PROG) ||
           (op == sfs_pkg::OP_ERASE_4K) || (op == sfs_pkg::OP_ERASE_32K) ||
           (op == sfs_pkg::OP_ERASE_64K) || (op == sfs_pkg::OP_PROTECT) ||
           (op == sfs_pkg::OP_UNPROTECT);
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  sfs_pkg::sfs_state_t st_q, st_d;
  sfs_pkg::sfs_cmd_t   cmd_q, cmd_d;
  sfs_pkg::sfs_wr_t    pw_q, pw_d;
  logic                sck_q, cs_q, opv_q, opv_d, aok_q, aok_d, dual_q, dual_d;
  logic [2:0]          bit_q, bit_d, obit_q, obit_d;
  logic [7:0]          sh_q, sh_d, op_q, op_d, osh_q, osh_d, off_q, off_d;
  logic [23:0]         addr_q, addr_d;
  logic [1:0]          abyte_q, abyte_d;
  logic [8:0]          cnt_q, cnt_d;
  logic                pend_q, pend_d, ovr_q, ovr_d, cmdv_q, cmdv_d, sby_q, sby_d;
  logic                hi_q, hi_d, lo_q, lo_d;
  logic [31:0]         prot_q, prot_d;
  logic [127:0]        secw_q, secw_d;
  logic [7:0]          sec_mem [sfs_pkg::SEC_BYTES];

  logic                rise, fall, cs_fall, cs_rise, dual_in, go, sec_we, fifo_ready;
  logic [7:0]          sh_in, nb;
  logic [2:0]          step;
  sfs_pkg::sfs_kind_t  kind;
  logic [23:0]         mask;

  // Edges count only while selected and not paused
  assign rise    = sck && !sck_q && !cs_n && hold_n;
  assign fall    = !sck && sck_q && !cs_n && hold_n;
  assign cs_fall = !cs_n && cs_q;
  assign cs_rise = cs_n && !cs_q;
  assign dual_in = (st_q == sfs_pkg::ST_WDATA) && dual_q;
  assign sh_in   = dual_in ? {sh_q[5:0], output_line_dual_input_i, input_line_dual_output_i}
                           : {sh_q[6:0], input_line_dual_output_i};
  assign step    = dual_q ? sfs_pkg::BIT_STEP_DUAL : sfs_pkg::BIT_STEP_SINGLE;
  assign nb      = (op_q == sfs_pkg::OP_SEC_READ) ? sec_mem[addr_q[sfs_pkg::SEC_AW-1:0]]
                                                  : rd_data;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q; bit_d = bit_q; sh_d = sh_q; op_d = op_q; opv_d = opv_q;
    aok_d = aok_q; dual_d = dual_q; addr_d = addr_q; abyte_d = abyte_q;
    cnt_d = cnt_q; off_d = off_q; pw_d = pw_q; ovr_d = ovr_q;
    osh_d = osh_q; obit_d = obit_q; hi_d = hi_q; lo_d = lo_q;
    prot_d = prot_q; secw_d = secw_q; cmd_d = cmd_q;
    pend_d = pend_q && !fifo_ready;
    cmdv_d = 1'b0;
    sec_we = 1'b0;
    go     = 1'b0;
    kind   = sfs_pkg::CMD_PROG;
    mask   = sfs_pkg::MASK_NONE;
    sby_d  = cs_n && !busy;
    if (cs_rise) begin
      st_d = sfs_pkg::ST_IDLE;
      case (op_q)
        sfs_pkg::OP_ERASE_4K: begin
          go = aok_q; kind = sfs_pkg::CMD_ERASE_4K; mask = sfs_pkg::MASK_4K;
        end
        sfs_pkg::OP_ERASE_32K: begin
          go = aok_q; kind = sfs_pkg::CMD_ERASE_32K; mask = sfs_pkg::MASK_32K;
        end
        sfs_pkg::OP_ERASE_64K: begin
          go = aok_q; kind = sfs_pkg::CMD_ERASE_64K; mask = sfs_pkg::MASK_64K;
        end
        sfs_pkg::OP_ERASE_CHIP: begin
          go = opv_q && (prot_q == '0); kind = sfs_pkg::CMD_ERASE_CHIP;
          mask = sfs_pkg::MASK_ALL;
        end
        sfs_pkg::OP_PROG, sfs_pkg::OP_PROG_DUAL: begin
          go = aok_q && (cnt_q != '0);
        end
        sfs_pkg::OP_PROTECT: begin
          if (aok_q) prot_d[sect_of(addr_q)] = 1'b1;
        end
        sfs_pkg::OP_UNPROTECT: begin
          if (aok_q) prot_d[sect_of(addr_q)] = 1'b0;
        end
        sfs_pkg::OP_PROTECT_ALL: begin
          if (opv_q) prot_d = '1;
        end
        sfs_pkg::OP_UNPROT_ALL: begin
          if (opv_q) prot_d = '0;
        end
        default: ;
      endcase
      // Protected or busy targets are dropped silently
      if (go && !busy && !prot_q[sect_of(addr_q)]) begin
        cmdv_d = 1'b1;
        cmd_d  = '{kind: kind, addr: addr_q & mask, len: cnt_q};
      end
    end else if (cs_fall) begin
      st_d = sfs_pkg::ST_OPC; bit_d = '0; abyte_d = '0; cnt_d = '0;
      opv_d = 1'b0; aok_d = 1'b0; dual_d = 1'b0; obit_d = '0; ovr_d = 1'b0;
    end else if (rise && (st_q != sfs_pkg::ST_RDATA) && (st_q != sfs_pkg::ST_SKIP)) begin
      sh_d  = sh_in;
      bit_d = bit_q + (dual_in ? sfs_pkg::BIT_STEP_DUAL : sfs_pkg::BIT_STEP_SINGLE);
      if (bit_q == (dual_in ? sfs_pkg::BIT_LAST_DUAL : sfs_pkg::BIT_LAST_SINGLE)) begin
        bit_d = '0;
        case (st_q)
          sfs_pkg::ST_OPC: begin
            op_d   = sh_in; opv_d = 1'b1;
            dual_d = (sh_in == sfs_pkg::OP_READ_DUAL) || (sh_in == sfs_pkg::OP_PROG_DUAL);
            st_d   = needs_addr(sh_in) ? sfs_pkg::ST_ADDR : sfs_pkg::ST_SKIP;
          end
          sfs_pkg::ST_ADDR: begin
            addr_d  = {addr_q[15:0], sh_in};
            abyte_d = abyte_q + 2'h1;
            if (abyte_q == sfs_pkg::ADDR_LAST) begin
              aok_d = 1'b1; off_d = sh_in; st_d = sfs_pkg::ST_SKIP;
              if (is_read(op_q)) begin
                st_d = sfs_pkg::ST_RDATA;
              end else if ((op_q == sfs_pkg::OP_SEC_PROG) ||
                           (is_prog(op_q) && !busy && !prot_q[sect_of(addr_d)])) begin
                st_d = sfs_pkg::ST_WDATA;
              end
            end
          end
          sfs_pkg::ST_WDATA: begin
            off_d = off_q + 8'h1;
            if (op_q == sfs_pkg::OP_SEC_PROG) begin
              // One write per byte until reset clears secw_q; later writes leave it alone
              if (!secw_q[off_q[sfs_pkg::SEC_AW-1:0]]) begin
                sec_we = 1'b1;
                secw_d[off_q[sfs_pkg::SEC_AW-1:0]] = 1'b1;
              end
            end else if (pend_q && !fifo_ready) begin
              ovr_d = 1'b1;
            end else begin
              pend_d = 1'b1;
              pw_d   = '{off: off_q, data: sh_in};
              if (cnt_q != sfs_pkg::PAGE_BYTES) cnt_d = cnt_q + 9'h1;
            end
          end
          default: ;
        endcase
      end
    end else if (fall && (st_q == sfs_pkg::ST_RDATA)) begin
      obit_d = obit_q + step;
      if (obit_q == '0) begin
        addr_d = addr_q + 24'h1;
        hi_d   = nb[7];
        lo_d   = nb[6];
        osh_d  = dual_q ? {nb[5:0], 2'b00} : {nb[6:0], 1'b0};
      end else begin
        hi_d  = osh_q[7];
        lo_d  = osh_q[6];
        osh_d = dual_q ? {osh_q[5:0], 2'b00} : {osh_q[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= sfs_pkg::ST_IDLE; sck_q <= 1'b0; cs_q <= 1'b1;
      bit_q <= '0; sh_q <= '0; op_q <= '0; opv_q <= 1'b0; aok_q <= 1'b0;
      dual_q <= 1'b0; addr_q <= '0; abyte_q <= '0; cnt_q <= '0; off_q <= '0;
      pend_q <= 1'b0; pw_q <= '0; ovr_q <= 1'b0; osh_q <= '0; obit_q <= '0;
      hi_q <= 1'b0; lo_q <= 1'b0; prot_q <= '0; secw_q <= '0;
      cmd_q <= '0; cmdv_q <= 1'b0; sby_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d; sck_q <= sck; cs_q <= cs_n;
      bit_q <= bit_d; sh_q <= sh_d; op_q <= op_d; opv_q <= opv_d; aok_q <= aok_d;
      dual_q <= dual_d; addr_q <= addr_d; abyte_q <= abyte_d; cnt_q <= cnt_d;
      off_q <= off_d; pend_q <= pend_d; pw_q <= pw_d; ovr_q <= ovr_d;
      osh_q <= osh_d; obit_q <= obit_d; hi_q <= hi_d; lo_q <= lo_d;
      prot_q <= prot_d; secw_q <= secw_d; cmd_q <= cmd_d; cmdv_q <= cmdv_d;
      sby_q <= sby_d;
    end
  end

  // Security bytes keep no reset so a reset does not erase them
  always_ff @(posedge clk) begin
    if (ce && sec_we) begin
      sec_mem[off_q[sfs_pkg::SEC_AW-1:0]] <= sh_in;
    end
  end

  // ------------------------------------------------------------------
  // Write data buffer toward the array
  // ------------------------------------------------------------------
  sfs_fifo #(
    .WIDTH ($bits(sfs_pkg::sfs_wr_t)),
    .DEPTH (sfs_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (pend_q),
    .in_ready  (fifo_ready),
    .in_data   (pw_q),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign output_line_dual_input_oe = !cs_n && hold_n && (st_q == sfs_pkg::ST_RDATA);
  assign input_line_dual_output_oe = output_line_dual_input_oe && dual_q;
  assign output_line_dual_input_o  = hi_q;
  assign input_line_dual_output_o  = lo_q;
  assign rd_addr     = addr_q;
  assign cmd_valid   = cmdv_q;
  assign cmd         = cmd_q;
  assign protect_map = prot_q;
  assign standby     = sby_q;
  assign overrun     = ovr_q;

endmodule // sfs_front_end

// ==== sfs_front_end_monitor.sv ====
// Concurrent checks on the pins of the serial flash front end.
// Assumes it is bound into sfs_front_end and sees only its ports.
`timescale 1ns/1ps

module sfs_front_end_monitor (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // SPI pins
  input wire logic              cs_n,
  input wire logic              sck,
  input wire logic              hold_n,
  input wire logic              input_line_dual_output_oe,
  input wire logic              output_line_dual_input_o,
  input wire logic              output_line_dual_input_oe,
  // Array side
  input wire logic              busy,
  input wire logic              cmd_valid,
  input wire sfs_pkg::sfs_cmd_t cmd,
  input wire logic              wr_valid,
  input wire logic              wr_ready,
  input wire sfs_pkg::sfs_wr_t  wr_word,
  input wire logic [31:0]       protect_map,
  input wire logic              standby
);
  // ----------
  // Helpers
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  function automatic logic [23:0] emask(input sfs_pkg::sfs_kind_t k);
    case (k)
      sfs_pkg::CMD_ERASE_4K:  return sfs_pkg::MASK_4K;
      sfs_pkg::CMD_ERASE_32K: return sfs_pkg::MASK_32K;
      sfs_pkg::CMD_ERASE_64K: return sfs_pkg::MASK_64K;
      default:                return sfs_pkg::MASK_ALL;
    endcase
  endfunction

  // Inside a frame, not at its start, and no serial clock fall seen
  sequence quiet_s;
    !cs_n && !$past(cs_n) && !$fell(sck);
  endsequence

  // ----------
  // Assertions
  // ----------
  deselect_float_a: assert property (cs_n |-> !input_line_dual_output_oe && !output_line_dual_input_oe)
    else $error("data pin driven while deselected");
  hold_float_a: assert property (!hold_n |-> !input_line_dual_output_oe && !output_line_dual_input_oe)
    else $error("data pin driven while paused");
  dual_pair_a: assert property (input_line_dual_output_oe |-> output_line_dual_input_oe)
    else $error("input line driven without output line");
  standby_track_a: assert property ($past(rst_n) |-> standby == ($past(cs_n) && !$past(busy)))
    else $error("standby not following select and busy");
  out_hold_a: assert property (quiet_s |=> $stable(output_line_dual_input_o))
    else $error("read bit moved without a clock fall");
  cmd_pulse_a: assert property (cmd_valid |-> $past(cs_n) ##1 !cmd_valid)
    else $error("command not a single pulse after frame end");
  erase_mask_a: assert property (cmd_valid && cmd.kind != sfs_pkg::CMD_PROG |-> (cmd.addr & ~emask(cmd.kind)) == 24'h000000)
    else $error("erase address not aligned");
  prog_len_a: assert property (cmd_valid && cmd.kind == sfs_pkg::CMD_PROG |-> cmd.len inside {[9'h001:9'h100]})
    else $error("program length out of range");
  prot_block_a: assert property (cmd_valid |-> (cmd.kind == sfs_pkg::CMD_ERASE_CHIP) ? protect_map == 32'h0 : !protect_map[cmd.addr[20:16]])
    else $error("command issued into protected area");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("write word dropped while stalled");
endmodule // sfs_front_end_monitor

bind sfs_front_end sfs_front_end_monitor u_mon (.clk, .rst_n, .cs_n, .sck, .hold_n,
  .input_line_dual_output_oe, .output_line_dual_input_o, .output_line_dual_input_oe, .busy,
  .cmd_valid, .cmd, .wr_valid, .wr_ready, .wr_word, .protect_map, .standby);

// ==== sfs_host_model.sv ====
// Behavioural SPI host that frames commands towards the flash front end.
// Assumes one caller process; pins move just after rising clk edges.
`timescale 1ns/1ps

module sfs_host_model (
  // Clock
  input  wire logic clk,
  // Pins towards the device
  output logic      cs_n,
  output logic      sck,
  output logic      hold_n,
  output logic      line0,
  output logic      line1,
  // Device drive
  input  wire logic dev0_o,
  input  wire logic dev0_oe,
  input  wire logic dev1_o,
  input  wire logic dev1_oe
);
  logic h0 = 1'b0, h1 = 1'b0, e0 = 1'b0, e1 = 1'b0, tog = 1'b0, m3 = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    hold_n = 1'b1;
  end
  always @(posedge clk) tog <= ~tog;
  // Undriven lines toggle so a stale level can never pass for data
  assign line0 = dev0_oe ? dev0_o : (e0 ? h0 : tog);
  assign line1 = dev1_oe ? dev1_o : (e1 ? h1 : ~tog);

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start(input logic mode3);
    @(posedge clk);
    m3 = mode3;
    sck <= mode3;
    tick(2);
    cs_n <= 1'b0;
    tick(2);
  endtask
  // Width w of 2 moves bit pairs: line1 carries the higher bit
  task automatic xbyte(input logic [7:0] tx, input int w, input logic rd, output logic [7:0] rx);
    for (int i = 0; i < 8; i += w) begin
      @(posedge clk);
      sck <= 1'b0;
      e0 <= !(rd && w == 2);
      e1 <= w == 2 && !rd;
      h1 <= tx[7-i];
      h0 <= (w == 2) ? tx[6-i] : tx[7-i];
      tick(2);
      sck <= 1'b1;
      rx = (w == 2) ? {rx[5:0], line1, line0} : {rx[6:0], line1};
      tick(1);
    end
  endtask
  task automatic pause(input int n);
    @(posedge clk);
    sck <= 1'b0;
    tick(2);
    hold_n <= 1'b0;
    repeat (2 * n) begin
      tick(2);
      sck <= ~sck;
      h0 <= ~h0;
    end
    tick(2);
    hold_n <= 1'b1;
    tick(2);
  endtask
  task automatic stop;
    @(posedge clk);
    sck <= m3;
    tick(2);
    cs_n <= 1'b1;
    e0 <= 1'b0;
    e1 <= 1'b0;
    tick(3);
  endtask
endmodule // sfs_host_model

// ==== sfs_pkg.sv ====
// Shared constants and types for the serial flash front end.
// Assumes a single 100 MHz clock and synchronous SPI pins.
package sfs_pkg;

  // ----------
  // Framing and field positions
  // ----------
  localparam int         ADDR_W          = 24;
  localparam logic [1:0] ADDR_LAST       = 2'h2;
  localparam logic [2:0] BIT_LAST_SINGLE = 3'h7;
  localparam logic [2:0] BIT_LAST_DUAL   = 3'h6;
  localparam logic [2:0] BIT_STEP_SINGLE = 3'h1;
  localparam logic [2:0] BIT_STEP_DUAL   = 3'h2;
  localparam logic [8:0] PAGE_BYTES      = 9'h100;
  localparam int         SECT_LSB        = 16;
  localparam int         SECT_W          = 5;
  localparam int         SECT_NUM        = 32;
  localparam int         SEC_BYTES       = 128;
  localparam int         SEC_AW          = 7;
  localparam int         FIFO_DEPTH      = 16;

  // ----------
  // Erase alignment masks
  // ----------
  localparam logic [23:0] MASK_4K   = 24'hfff000;
  localparam logic [23:0] MASK_32K  = 24'hff8000;
  localparam logic [23:0] MASK_64K  = 24'hff0000;
  localparam logic [23:0] MASK_NONE = 24'hffffff;
  localparam logic [23:0] MASK_ALL  = 24'h000000;

  // ----------
  // Opcodes
  // ----------
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_READ_DUAL   = 8'h3b;
  localparam logic [7:0] OP_PROG        = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL   = 8'ha2;
  localparam logic [7:0] OP_ERASE_4K    = 8'h20;
  localparam logic [7:0] OP_ERASE_32K   = 8'h52;
  localparam logic [7:0] OP_ERASE_64K   = 8'hd8;
  localparam logic [7:0] OP_ERASE_CHIP  = 8'h60;
  localparam logic [7:0] OP_PROTECT     = 8'h36;
  localparam logic [7:0] OP_UNPROTECT   = 8'h39;
  localparam logic [7:0] OP_PROTECT_ALL = 8'h3c;
  localparam logic [7:0] OP_UNPROT_ALL  = 8'h3d;
  localparam logic [7:0] OP_SEC_PROG    = 8'h9b;
  localparam logic [7:0] OP_SEC_READ    = 8'h77;

  // ----------
  // Types
  // ----------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_OPC   = 6'h02,
    ST_ADDR  = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_SKIP  = 6'h20
  } sfs_state_t;

  typedef enum logic [2:0] {
    CMD_PROG       = 3'h0,
    CMD_ERASE_4K   = 3'h1,
    CMD_ERASE_32K  = 3'h2,
    CMD_ERASE_64K  = 3'h3,
    CMD_ERASE_CHIP = 3'h4
  } sfs_kind_t;

  typedef struct packed {
    sfs_kind_t   kind;
    logic [23:0] addr;
    logic [8:0]  len;
  } sfs_cmd_t;

  typedef struct packed {
    logic [7:0] off;
    logic [7:0] data;
  } sfs_wr_t;

endpackage

// ==== testbench.sv ====
// Self-checking bench for the serial flash front end with a host model.
// Assumes sfs_pkg, the design, the monitor and the host model come first.
`timescale 1ns/1ps

module testbench;
  // ----------
  // Signals and array model
  // ----------
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, busy = 1'b0, wr_ready = 1'b0, stall = 1'b0;
  logic cs_n, sck, hold_n, input_line_dual_output_i, input_line_dual_output_o;
  logic input_line_dual_output_oe, output_line_dual_input_i, output_line_dual_input_o;
  logic output_line_dual_input_oe, cmd_valid, wr_valid, standby, overrun;
  logic [23:0] rd_addr;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] dat [32];
  logic [31:0] protect_map;
  sfs_pkg::sfs_cmd_t cmd, last;
  sfs_pkg::sfs_wr_t wr_word;
  sfs_pkg::sfs_wr_t wq [$];
  int mismatches = 0, n_tests = 0, n_cmd = 0, cyc = 0;
  localparam logic [7:0] EOP [4] = '{sfs_pkg::OP_ERASE_4K, sfs_pkg::OP_ERASE_32K,
                                     sfs_pkg::OP_ERASE_64K, sfs_pkg::OP_ERASE_CHIP};
  localparam logic [23:0] EMK [4] = '{sfs_pkg::MASK_4K, sfs_pkg::MASK_32K,
                                      sfs_pkg::MASK_64K, sfs_pkg::MASK_ALL};
  always #5 clk = ~clk;

  function automatic logic [7:0] arr(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_data <= arr(rd_addr);
    wr_ready <= !stall && $urandom_range(0, 3) != 0;
    if (cmd_valid) begin
      last <= cmd;
      n_cmd <= n_cmd + 1;
    end
    if (wr_valid && wr_ready) wq.push_back(wr_word);
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end

  sfs_front_end u_dut (.clk, .rst_n, .ce, .cs_n, .sck, .hold_n, .input_line_dual_output_i,
    .input_line_dual_output_o, .input_line_dual_output_oe, .output_line_dual_input_i,
    .output_line_dual_input_o, .output_line_dual_input_oe, .busy, .rd_addr, .rd_data, .cmd_valid,
    .cmd, .wr_valid, .wr_ready, .wr_word, .protect_map, .standby, .overrun);
  sfs_host_model u_host (.clk, .cs_n, .sck, .hold_n, .line0(input_line_dual_output_i),
    .line1(output_line_dual_input_i), .dev0_o(input_line_dual_output_o),
    .dev0_oe(input_line_dual_output_oe), .dev1_o(output_line_dual_input_o),
    .dev1_oe(output_line_dual_input_oe));

  // ----------
  // Checks and frames
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_cmd(input int n0, input sfs_pkg::sfs_kind_t k, input logic [23:0] a);
    chk(32'(n_cmd - n0), 32'h1, "command count");
    chk({5'h0, last.kind, last.addr}, {5'h0, k, a}, "command fields");
  endtask
  task automatic words(input logic [23:0] a, input int n);
    for (int i = 0; i < 300 && wq.size() < n; i++) @(posedge clk);
    for (int i = 0; i < n && i < wq.size(); i++) chk(32'(wq[i]), {16'h0, a[7:0] + 8'(i), dat[i]}, "word");
    chk(32'(wq.size() >= n), 32'h1, "word count");
  endtask
  task automatic frame(input logic m3, input logic [7:0] op, input logic [23:0] a, input int na,
                       input int nd, input int w, input logic rd, input int hp);
    logic [7:0] r;
    u_host.start(m3);
    u_host.xbyte(op, 1, 1'b0, r);
    for (int i = 0; i < na; i++) u_host.xbyte(a[23-8*i -: 8], 1, 1'b0, r);
    for (int i = 0; i < nd; i++) begin
      if (i == hp) u_host.pause(2);
      u_host.xbyte(rd ? 8'h00 : dat[i], w, rd, r);
      if (rd) chk({24'h0, r}, {24'h0, arr(a + 24'(i))}, "read byte");
    end
    u_host.stop();
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------
  // Tests
  // ----------
  initial begin
    int n0, len;
    logic [23:0] a;
    logic [7:0] r;
    void'($urandom(10216));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(protect_map, 32'h0, "protect reset");
    chk({31'h0, standby}, 32'h1, "standby reset");
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      len = (k == 1) ? 8 : $urandom_range(1, 12);
      a = 24'($urandom_range(0, 24'h1fffff));
      if (k == 1) a[7:0] = 8'hfc;
      foreach (dat[i]) dat[i] = 8'($urandom);
      n0 = n_cmd;
      wq.delete();
      frame(k[0], k == 2 ? sfs_pkg::OP_PROG_DUAL : sfs_pkg::OP_PROG, a, 3, len, k == 2 ? 2 : 1, 0, -1);
      words(a, len);
      chk_cmd(n0, sfs_pkg::CMD_PROG, a);
      chk({23'h0, last.len}, 32'(len), "program length");
    end
    $display("test program done");
    stall <= 1'b1;
    wq.delete();
    frame(0, sfs_pkg::OP_PROG, 24'h000010, 3, 24, 1, 0, -1);
    chk({30'h0, wr_valid, overrun}, 32'h3, "fifo full and overrun");
    stall <= 1'b0;
    words(24'h000010, 16);
    for (int k = 0; k < 3; k++) frame(k == 1, k == 2 ? sfs_pkg::OP_READ_DUAL : sfs_pkg::OP_READ,
                                      24'($urandom), 3, 6, k == 2 ? 2 : 1, 1, k == 0 ? 2 : -1);
    chk({31'h0, overrun}, 32'h0, "overrun cleared");
    $display("test read done");
    for (int k = 0; k < 4; k++) begin
      a = 24'($urandom_range(0, 24'h1fffff));
      n0 = n_cmd;
      frame(k[0], EOP[k], a, k < 3 ? 3 : 0, 0, 1, 0, -1);
      chk_cmd(n0, sfs_pkg::sfs_kind_t'(k + 1), k < 3 ? a & EMK[k] : 24'h000000);
    end
    $display("test erase done");
    a = {3'h0, 5'($urandom), 16'h1234};
    frame(0, sfs_pkg::OP_PROTECT, a, 3, 0, 1, 0, -1);
    chk(protect_map, 32'h1 << a[20:16], "protect one");
    n0 = n_cmd;
    frame(1, sfs_pkg::OP_ERASE_4K, a, 3, 0, 1, 0, -1);
    frame(0, sfs_pkg::OP_ERASE_CHIP, a, 0, 0, 1, 0, -1);
    chk(32'(n_cmd - n0), 32'h0, "protected refused");
    frame(0, sfs_pkg::OP_UNPROTECT, a, 3, 0, 1, 0, -1);
    chk(protect_map, 32'h0, "unprotect one");
    frame(0, sfs_pkg::OP_PROTECT_ALL, a, 0, 0, 1, 0, -1);
    chk(protect_map, 32'hffffffff, "protect all");
    frame(0, sfs_pkg::OP_UNPROT_ALL, a, 0, 0, 1, 0, -1);
    chk(protect_map, 32'h0, "unprotect all");
    $display("test protect done");
    busy <= 1'b1;
    n0 = n_cmd;
    frame(0, sfs_pkg::OP_PROG, 24'h000100, 3, 2, 1, 0, -1);
    chk({31'h0, standby}, 32'h0, "no standby while busy");
    chk(32'(n_cmd - n0), 32'h0, "busy refused");
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, standby}, 32'h1, "standby after busy");
    wq.delete();
    u_host.xbyte(sfs_pkg::OP_ERASE_CHIP, 1, 0, r);
    u_host.xbyte(sfs_pkg::OP_PROG, 1, 0, r);
    u_host.stop();
    chk(32'(n_cmd - n0 + wq.size()), 32'h0, "deselected ignored");
    $display("test deselect done");
    print_verdict();
  end
endmodule // testbench
